/* File: rtl/hscp_consts.vh */
`ifndef HSCP_CONSTS_VH
`define HSCP_CONSTS_VH
`define HSCP_FIFO_DEPTH 19
`define HSCP_SLOT_BITS 8
`define HSCP_CTRL_SLOT 5'h01
`define HSCP_SLOT_D0 2'h0
`define HSCP_SLOT_D2 2'h1
`define HSCP_SLOT_D3 2'h2
`define HSCP_SLOT_D4 2'h3
`define HSCP_WDOG_FRAMES 16'h0100
`define HSCP_IRQ_BITS 4
`endif

/* File: rtl/hscp_fifo.v */
`timescale 1ns/1ps
`include "hscp_consts.vh"
module hscp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = `HSCP_FIFO_DEPTH
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Write side
    input wire wr_valid,
    output wire wr_ready,
    input wire [WIDTH-1:0] wr_data,
    // Read side
    output wire rd_valid,
    input wire rd_ready,
    output wire [WIDTH-1:0] rd_data
);
    // Sized copies keep the pointer and count compares at their own widths
    localparam [5:0] FULL_COUNT = DEPTH;
    localparam [4:0] LAST_INDEX = DEPTH - 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [4:0] wp;
    reg [4:0] rp;
    reg [5:0] count;
    wire do_wr;
    wire do_rd;

    assign wr_ready = (count != FULL_COUNT);
    assign rd_valid = (count != 6'h00);
    assign rd_data = mem[rp];
    assign do_wr = wr_valid && wr_ready;
    assign do_rd = rd_valid && rd_ready;

    // Store of nineteen entries; reset empties it
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            wp <= 5'h00;
            rp <= 5'h00;
            count <= 6'h00;
        end else begin
            if (do_wr) begin
                mem[wp] <= wr_data;
                wp <= (wp == LAST_INDEX) ? 5'h00 : wp + 5'h01;
            end
            if (do_rd) begin
                rp <= (rp == LAST_INDEX) ? 5'h00 : rp + 5'h01;
            end
            if (do_wr && !do_rd) begin
                count <= count + 6'h01;
            end else if (do_rd && !do_wr) begin
                count <= count - 6'h01;
            end
        end
    end
endmodule

/* File: rtl/hscp_sync.v */
`timescale 1ns/1ps
module hscp_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta;

    // First stage is read by the second stage only
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            meta <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

/* File: rtl/hscp_port.v */
`timescale 1ns/1ps
`include "hscp_consts.vh"
module hscp_port #(
    parameter WDOG_FRAMES = `HSCP_WDOG_FRAMES
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Link pins
    input wire bit_clock_in,
    input wire frame_pulse_in,
    input wire tx_clock_enable_n,
    input wire rx_clock_enable_n,
    input wire serial_channel_in,
    output reg serial_channel_out,
    output wire serial_channel_oe,
    // Control
    input wire external_timing,
    input wire bit_rate_clock_select,
    input wire [1:0] data_slot_sel,
    input wire [7:0] control_tx,
    output reg [7:0] control_rx,
    // Transmit bytes
    input wire tx_valid,
    output wire tx_ready,
    input wire [7:0] tx_data,
    // Receive bytes
    output wire rx_valid,
    input wire rx_ready,
    output wire [7:0] rx_data,
    output wire rx_overrun,
    // Watchdog and interrupts
    input wire watchdog_kick,
    output wire watchdog_out_n,
    input wire [`HSCP_IRQ_BITS-1:0] irq_flags,
    input wire [`HSCP_IRQ_BITS-1:0] irq_enables,
    output wire interrupt_request_n,
    output wire interrupt_request_oe,
    // Register select pass-through for the host port decoder
    input wire [3:0] register_select_lines,
    output reg [3:0] register_select
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire [4:0] pins_s;
    reg ck_d;
    reg fp_d;
    wire ck;
    wire fp;
    wire txen_n;
    wire rxen_n;
    wire sin;

    hscp_sync #(.WIDTH(5)) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in({bit_clock_in, frame_pulse_in, tx_clock_enable_n,
                   rx_clock_enable_n, serial_channel_in}),
        .sync_out(pins_s)
    );
    assign ck = pins_s[4];
    assign fp = pins_s[3];
    assign txen_n = pins_s[2];
    assign rxen_n = pins_s[1];
    assign sin = pins_s[0];

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            ck_d <= 1'b0;
            fp_d <= 1'b0;
        end else begin
            ck_d <= ck;
            fp_d <= fp;
        end
    end

    wire ck_rise = ck && !ck_d;
    wire ck_fall = !ck && ck_d;
    wire fp_rise = fp && !fp_d;

    ////////////////////////////////////////////////////////////////////////
    // Bit timing
    // Double-rate clock halves into one bit per two falls
    reg half;
    wire int_tick = ck_fall && (!bit_rate_clock_select || half);
    wire tx_gate = external_timing ? !txen_n : 1'b1;
    wire rx_gate = external_timing ? !rxen_n : 1'b1;
    wire tx_tick = external_timing ? (ck_rise && tx_gate) : int_tick;
    wire rx_tick = external_timing ? (ck_fall && rx_gate) : int_tick;

    reg [2:0] bit_cnt;
    reg [4:0] slot;
    wire frame_start = !external_timing && fp_rise;

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            half <= 1'b0;
            bit_cnt <= 3'h0;
            slot <= 5'h00;
        end else if (frame_start) begin
            half <= 1'b0;
            bit_cnt <= 3'h0;
            slot <= 5'h00;
        end else if (external_timing) begin
            half <= 1'b0;
            // One count per bit: follow the transmit side when it runs
            if (tx_gate ? tx_tick : rx_tick) begin
                bit_cnt <= bit_cnt + 3'h1;
            end
        end else if (ck_fall) begin
            half <= !half;
            if (int_tick) begin
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    slot <= slot + 5'h01;
                end
            end
        end
    end

    // Data slot mapping: 0, 2, 3 or 4
    reg [4:0] data_slot;
    always @* begin
        case (data_slot_sel)
            `HSCP_SLOT_D0: data_slot = 5'h00;
            `HSCP_SLOT_D2: data_slot = 5'h02;
            `HSCP_SLOT_D3: data_slot = 5'h03;
            default: data_slot = 5'h04;
        endcase
    end
    wire in_data = external_timing || (slot == data_slot);
    wire in_ctrl = !external_timing && (slot == `HSCP_CTRL_SLOT);

    ////////////////////////////////////////////////////////////////////////
    // Byte stores
    wire txf_valid;
    wire [7:0] txf_data;
    wire txf_pop;
    reg rxf_push;
    reg [7:0] rxf_byte;
    wire rxf_ready;

    hscp_fifo #(.WIDTH(8), .DEPTH(`HSCP_FIFO_DEPTH)) u_txf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_valid(tx_valid),
        .wr_ready(tx_ready),
        .wr_data(tx_data),
        .rd_valid(txf_valid),
        .rd_ready(txf_pop),
        .rd_data(txf_data)
    );
    hscp_fifo #(.WIDTH(8), .DEPTH(`HSCP_FIFO_DEPTH)) u_rxf (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr_valid(rxf_push),
        .wr_ready(rxf_ready),
        .wr_data(rxf_byte),
        .rd_valid(rx_valid),
        .rd_ready(rx_ready),
        .rd_data(rx_data)
    );
    assign rx_overrun = rxf_push && !rxf_ready;

    ////////////////////////////////////////////////////////////////////////
    // Transmit shifter, NRZ, LSB first; idle sends ones
    reg [7:0] tx_sh;
    reg [7:0] ctl_sh;
    assign txf_pop = tx_tick && in_data && (bit_cnt == 3'h0) && txf_valid;

    always @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_sh <= 8'hff;
            ctl_sh <= 8'hff;
            serial_channel_out <= 1'b1;
        end else if (tx_tick) begin
            if (in_ctrl) begin
                if (bit_cnt == 3'h0) begin
                    serial_channel_out <= control_tx[0];
                    ctl_sh <= {1'b1, control_tx[7:1]};
                end else begin
                    serial_channel_out <= ctl_sh[0];
                    ctl_sh <= {1'b1, ctl_sh[7:1]};
                end
            end else if (in_data) begin
                if (bit_cnt == 3'h0) begin
                    serial_channel_out <= txf_valid ? txf_data[0] : 1'b1;
                    tx_sh <= txf_valid ? {1'b1, txf_data[7:1]} : 8'hff;
                end else begin
                    serial_channel_out <= tx_sh[0];
                    tx_sh <= {1'b1, tx_sh[7:1]};
                end
            end else begin
                serial_channel_out <= 1'b1;
            end
        end
    end
    // Output enable drops with the transmit enable under external timing; internal timing always drives
    assign serial_channel_oe = tx_gate;

    ////////////////////////////////////////////////////////////////////////
    // Receive shifter
    reg [7:0] rx_sh;
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            rx_sh <= 8'h00;
            rxf_push <= 1'b0;
            rxf_byte <= 8'h00;
            control_rx <= 8'h00;
        end else begin
            rxf_push <= 1'b0;
            if (rx_tick && (in_data || in_ctrl)) begin
                rx_sh <= {sin, rx_sh[7:1]};
                if (bit_cnt == 3'h7) begin
                    if (in_ctrl) begin
                        control_rx <= {sin, rx_sh[7:1]};
                    end else begin
                        rxf_byte <= {sin, rx_sh[7:1]};
                        rxf_push <= 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog counts frame pulses; kick restarts it
    localparam [15:0] WD_LAST = WDOG_FRAMES - 1;
    reg [15:0] wd_cnt;
    reg wd_expired;
    wire wd_step = fp_rise && !wd_expired;
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            wd_cnt <= 16'h0000;
            wd_expired <= 1'b0;
        end else begin
            if (watchdog_kick) begin
                wd_cnt <= 16'h0000;
                wd_expired <= 1'b0;
            end else if (wd_step) begin
                wd_cnt <= wd_cnt + 16'h0001;
            end
            // Expiry wins over a kick in the same cycle
            if (wd_step && (wd_cnt == WD_LAST)) begin
                wd_expired <= 1'b1;
            end
        end
    end
    // Held low through reset as well as on expiry
    assign watchdog_out_n = !(wd_expired || !reset_n);

    ////////////////////////////////////////////////////////////////////////
    // Open-drain interrupt: drive low only for enabled flags
    reg irq_any;
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            irq_any <= 1'b0;
            register_select <= 4'h0;
        end else begin
            irq_any <= |(irq_flags & irq_enables);
            register_select <= register_select_lines;
        end
    end
    assign interrupt_request_n = 1'b0;
    assign interrupt_request_oe = irq_any;
endmodule

/* File: bench/hscp_port_monitor.sv */
`timescale 1ns/1ps
module hscp_port_monitor #(parameter WDOG_FRAMES = 4) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // Link side
    input wire tx_clock_enable_n,
    input wire rx_clock_enable_n,
    input wire external_timing,
    input wire serial_channel_oe,
    input wire rx_valid,
    // Host side
    input wire watchdog_out_n,
    input wire [3:0] irq_flags,
    input wire [3:0] irq_enables,
    input wire interrupt_request_n,
    input wire interrupt_request_oe,
    input wire [3:0] register_select_lines,
    input wire [3:0] register_select
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    // Reset itself is the cause here, so it must not disable the check
    a_wdog_reset_low: assert property (disable iff (1'b0) !reset_n |-> !watchdog_out_n)
        else $error("watchdog high during reset");
    a_irq_pin_low: assert property (interrupt_request_oe |-> !interrupt_request_n)
        else $error("interrupt pin driven high");
    a_irq_on_enable: assert property (|(irq_flags & irq_enables) |=> interrupt_request_oe)
        else $error("enabled flag gave no interrupt");
    a_irq_masked_off: assert property (!(|(irq_flags & irq_enables)) |=> !interrupt_request_oe)
        else $error("interrupt without enabled flag");
    a_tx_off_hiz: assert property ((external_timing && tx_clock_enable_n)[*4] |-> !serial_channel_oe)
        else $error("output driven while disabled");
    a_tx_on_drive: assert property ((external_timing && !tx_clock_enable_n)[*4] |-> serial_channel_oe)
        else $error("output not driven while enabled");
    a_rx_stays_quiet: assert property ((external_timing && rx_clock_enable_n && !rx_valid)[*8] |=> !rx_valid)
        else $error("byte received while disabled");
    a_select_copy: assert property (1'b1 |=> register_select == $past(register_select_lines))
        else $error("register select not copied");
endmodule
bind hscp_port hscp_port_monitor #(.WDOG_FRAMES(WDOG_FRAMES)) mon_u (.clk_sys, .reset_n,
    .tx_clock_enable_n, .rx_clock_enable_n, .external_timing, .serial_channel_oe, .rx_valid,
    .watchdog_out_n, .irq_flags, .irq_enables, .interrupt_request_n, .interrupt_request_oe,
    .register_select_lines, .register_select);

/* File: bench/hscp_partner.sv */
`timescale 1ns/1ps
module hscp_partner (
    // Frame control
    input wire run,
    input wire double,
    input wire [2:0] slot,
    input wire [7:0] ctrl_byte,
    // Line
    output reg bit_clock_in,
    output reg frame_pulse_in,
    output reg serial_channel_in,
    input wire serial_channel_out,
    // Bytes seen and sent
    output reg [7:0] cap_ctrl,
    output reg [7:0] cap_data,
    output reg cap_valid,
    output reg [7:0] sent_data
);
    localparam FRAME_BITS = 48;
    integer k;
    initial begin
        bit_clock_in = 1'b1;
        frame_pulse_in = 1'b0;
        serial_channel_in = 1'b1;
        cap_valid = 1'b0;
        sent_data = 8'h5a;
        forever begin
            wait (run);
            sent_data = sent_data + 8'h35;
            #1 frame_pulse_in = 1'b1;
            #100;
            for (k = 0; k < FRAME_BITS; k = k + 1) begin
                bit_clock_in = 1'b0;
                // Control in slot one, data in chosen slot, idle ones elsewhere
                serial_channel_in = (k / 8 == 1) ? ctrl_byte[k % 8] :
                    ((k / 8 == slot) ? sent_data[k % 8] : 1'b1);
                #100 bit_clock_in = 1'b1;
                frame_pulse_in = 1'b0;
                // Double rate: a second clock per bit, the bit tick is its fall
                if (double) begin
                    #100 bit_clock_in = 1'b0;
                    #100 bit_clock_in = 1'b1;
                end
                // Sample late in the bit: the pin lags the falling edge by the sync stages
                #50;
                if (k / 8 == 1) cap_ctrl[k % 8] = serial_channel_out;
                if (k / 8 == slot) cap_data[k % 8] = serial_channel_out;
                #50;
            end
            // Clock stands still between frames; a stale bit must not look valid
            serial_channel_in = ~serial_channel_in;
            cap_valid = 1'b1;
            #25 cap_valid = 1'b0;
        end
    end
endmodule

/* File: bench/hdlc_serial_port_pins_test.sv */
`timescale 1ns/1ps
module hdlc_serial_port_pins_test;
    reg clk_sys, reset_n, tx_clock_enable_n, rx_clock_enable_n, external_timing;
    reg tx_valid, rx_ready, watchdog_kick, kick_on, run, brcs;
    reg [1:0] data_slot_sel;
    reg [7:0] control_tx, tx_data, peer_ctrl;
    reg [3:0] irq_flags, irq_enables, register_select_lines;
    reg [8:0] cyc;
    wire bit_clock_in, frame_pulse_in, serial_channel_in, serial_channel_out;
    wire serial_channel_oe, tx_ready, rx_valid, watchdog_out_n, cap_valid;
    // Pulled-up line: released output reads high at the partner
    wire line_out = serial_channel_oe ? serial_channel_out : 1'b1;
    wire [7:0] rx_data, control_rx, cap_ctrl, cap_data, sent_data;
    wire [2:0] slot = {1'b0, data_slot_sel} + {2'b00, data_slot_sel != 2'b00};
    integer seed = 32'hdb8071bf;
    integer fails = 0;
    integer compares = 0;
    integer i;
    reg [7:0] exp_tx[$];
    reg [7:0] exp_rx[$];
    hscp_port #(.WDOG_FRAMES(4)) dut_u (.clk_sys, .reset_n, .bit_clock_in, .frame_pulse_in,
        .tx_clock_enable_n, .rx_clock_enable_n, .serial_channel_in, .serial_channel_out,
        .serial_channel_oe, .external_timing, .bit_rate_clock_select(brcs), .data_slot_sel,
        .control_tx, .control_rx, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready,
        .rx_data, .rx_overrun(), .watchdog_kick, .watchdog_out_n, .irq_flags, .irq_enables,
        .interrupt_request_n(), .interrupt_request_oe(), .register_select_lines,
        .register_select());
    hscp_partner peer_u (.run, .double(brcs), .slot, .ctrl_byte(peer_ctrl), .bit_clock_in,
        .frame_pulse_in, .serial_channel_in, .serial_channel_out(line_out), .cap_ctrl,
        .cap_data, .cap_valid, .sent_data);
    ////////////////////////////////////////////////////////////////
    task check_byte(input [7:0] got, input [7:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("compares %0d fails %0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task push_tx(input [7:0] d);
        begin
            tx_data <= d;
            tx_valid <= 1'b1;
            @(posedge clk_sys);
            while (!tx_ready) @(posedge clk_sys);
            tx_valid <= 1'b0;
            exp_tx.push_back(d);
            @(posedge clk_sys);
        end
    endtask
    task frames(input integer n);
        begin
            run = 1'b1;
            repeat (n) @(posedge cap_valid);
            run = 1'b0;
            repeat (8) @(posedge clk_sys);
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 9'h001;
        watchdog_kick <= kick_on && (cyc[7:0] == 8'h00);
        {irq_flags, irq_enables, register_select_lines} <= 12'($random(seed));
    end
    // Result watchers take the oldest note when a byte shows up
    always @(posedge frame_pulse_in)
        if (!external_timing) exp_rx.push_back(sent_data);
    always @(posedge clk_sys)
        if (rx_valid && rx_ready) check_byte(rx_data, exp_rx.size() ? exp_rx.pop_front() : 8'hxx);
    always @(posedge cap_valid)
        if (!external_timing) begin
            check_byte(cap_ctrl, control_tx);
            if (cap_data !== 8'hff) check_byte(cap_data, exp_tx.size() ? exp_tx.pop_front() : 8'hxx);
        end
    initial begin
        #1000000;
        fails = fails + 1;
        report_and_stop;
    end
    initial begin
        {reset_n, tx_valid, watchdog_kick, run, external_timing, brcs} = 6'h00;
        {tx_clock_enable_n, rx_clock_enable_n, rx_ready, kick_on} = 4'hf;
        {data_slot_sel, control_tx, tx_data, peer_ctrl, cyc} = 35'h0;
        {irq_flags, irq_enables, register_select_lines} = 12'h000;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        check_byte({7'h00, watchdog_out_n}, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            data_slot_sel <= i[1:0];
            brcs <= i[0];
            // Internal timing must not care about the enable levels
            tx_clock_enable_n <= i[1];
            rx_clock_enable_n <= i[0];
            control_tx <= 8'($random(seed));
            peer_ctrl <= 8'($random(seed));
            repeat (3) push_tx(8'($random(seed)) & 8'hfe);
            frames(5);
            check_byte(control_rx, peer_ctrl);
            check_byte(8'(exp_tx.size()), 8'h00);
        end
        external_timing <= 1'b1;
        brcs <= 1'b0;
        frames(2);
        tx_clock_enable_n <= 1'b0;
        frames(2);
        external_timing <= 1'b0;
        kick_on <= 1'b0;
        frames(6);
        check_byte({7'h00, watchdog_out_n}, 8'h00);
        reset_n <= 1'b0;
        kick_on <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check_byte({7'h00, watchdog_out_n}, 8'h00);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check_byte({7'h00, watchdog_out_n}, 8'h01);
        report_and_stop;
    end
endmodule
